/* verilog/regulator_delay_fault_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module regulator_delay_fault_regs
  import regulator_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       second_enable,
  output logic            second_on,
  output logic      [1:0] discharge_current_select,
  input  wire analog_status_t third_status,
  output logic            interrupt_request_low
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] next_sync_a;
  logic [4:0] next_sync_b;

  always_comb begin
    next_sync_a = {second_enable, third_status};
    next_sync_b = sync_a;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
    end
  end

  logic enable_s;
  logic third_output_good;
  logic over_v;
  logic over_i;
  logic sw_cycle;
  assign enable_s          = sync_b[4];
  assign third_output_good = sync_b[3];
  assign over_v            = sync_b[2];
  assign over_i            = sync_b[1];
  assign sw_cycle          = sync_b[0];

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] delay_cfg;
  logic [3:1] masks;
  logic       high_voltage_flag;
  logic       third_current_limit_flag;
  logic [4:0] limit_run;
  logic       prev_cycle;
  logic [7:0] next_delay_cfg;
  logic [3:1] next_masks;
  logic       next_hv_flag;
  logic       next_il_flag;
  logic [4:0] next_limit_run;
  logic       fault_read;
  logic       cycle_edge;

  assign fault_read = reg_read && (reg_addr == ADDR_FAULT_STAT);
  assign cycle_edge = sw_cycle && !prev_cycle;

  always_comb begin
    next_delay_cfg = delay_cfg;
    next_masks     = masks;
    if (reg_write && reg_addr == ADDR_DELAY_CFG) begin
      next_delay_cfg = reg_wdata;
    end
    if (reg_write && reg_addr == ADDR_FAULT_STAT) begin
      next_masks = reg_wdata[FLT_UV_MASK:FLT_IL_MASK];
    end
    // Counting switching edges keeps a long-held overload from counting per clock.
    next_limit_run = limit_run;
    if (!over_i) begin
      next_limit_run = 5'h00;
    end else if (cycle_edge && limit_run != 5'(CURRENT_COUNT)) begin
      next_limit_run = limit_run + 5'h01;
    end
    // Clearing needs both the condition gone and a read; setting always wins.
    next_hv_flag = high_voltage_flag;
    if (over_v) begin
      next_hv_flag = 1'b1;
    end else if (fault_read) begin
      next_hv_flag = 1'b0;
    end
    next_il_flag = third_current_limit_flag;
    if (next_limit_run == 5'(CURRENT_COUNT)) begin
      next_il_flag = 1'b1;
    end else if (fault_read && !over_i) begin
      next_il_flag = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      delay_cfg                <= RESET_DELAY_CFG;
      masks                    <= RESET_MASKS[3:1];
      high_voltage_flag        <= 1'b0;
      third_current_limit_flag <= 1'b0;
      limit_run                <= 5'h00;
      prev_cycle               <= 1'b0;
    end else begin
      delay_cfg                <= next_delay_cfg;
      masks                    <= next_masks;
      high_voltage_flag        <= next_hv_flag;
      third_current_limit_flag <= next_il_flag;
      limit_run                <= next_limit_run;
      prev_cycle               <= sw_cycle;
    end
  end

  logic [7:0] fault_view;
  logic [7:0] next_rdata;
  always_comb begin
    fault_view              = 8'h00;
    fault_view[FLT_GOOD]    = third_output_good;
    fault_view[FLT_HIGH_V]  = high_voltage_flag;
    fault_view[FLT_CURRENT] = third_current_limit_flag;
    fault_view[FLT_UV_MASK:FLT_IL_MASK] = masks;
    // The reserved bit is read-only and always returns its reset level.
    fault_view[FLT_RSVD]    = RESET_MASKS[FLT_RSVD];
    case (reg_addr)
      ADDR_DELAY_CFG:  next_rdata = delay_cfg;
      ADDR_FAULT_STAT: next_rdata = fault_view;
      default:         next_rdata = 8'h00;
    endcase
  end

  // ****************************************************************
  // Sequencing delay
  // ****************************************************************
  seq_state_t state;
  seq_state_t next_state;
  logic [15:0] tick_div;
  logic [15:0] next_tick_div;
  logic [6:0]  ticks;
  logic [6:0]  next_ticks;
  logic        tick;
  logic        next_on;
  logic        next_irq_low;
  logic        fault_pending;

  assign tick = (tick_div == 16'(TICK_CYCLES - 1));

  always_comb begin
    next_tick_div = tick ? 16'h0000 : tick_div + 16'h0001;
    next_state    = state;
    next_ticks    = ticks;
    case (state)
      REG_OFF: begin
        if (enable_s) begin
          next_state = REG_WAIT_ON;
          next_ticks = delay_ticks(delay_cfg[DLY_ON_HI:DLY_ON_LO]);
          next_tick_div = 16'h0000;
        end
      end
      REG_WAIT_ON: begin
        if (!enable_s) begin
          next_state = REG_OFF;
        end else if (ticks == 7'h00) begin
          next_state = REG_ON;
        end else if (tick) begin
          next_ticks = ticks - 7'h01;
        end
      end
      REG_ON: begin
        if (!enable_s) begin
          next_state = REG_WAIT_OFF;
          next_ticks = delay_ticks(delay_cfg[DLY_OFF_HI:DLY_OFF_LO]);
          next_tick_div = 16'h0000;
        end
      end
      REG_WAIT_OFF: begin
        if (enable_s) begin
          next_state = REG_ON;
        end else if (ticks == 7'h00) begin
          next_state = REG_OFF;
        end else if (tick) begin
          next_ticks = ticks - 7'h01;
        end
      end
      default: next_state = REG_OFF;
    endcase
    next_on = (next_state == REG_ON) || (next_state == REG_WAIT_OFF);
    // Live power-good status and the sticky flags feed the fault logic; a dead output counts as undervoltage.
    fault_pending = (!third_output_good && !masks[FLT_UV_MASK])
                  || (high_voltage_flag && !masks[FLT_OV_MASK])
                  || (third_current_limit_flag && !masks[FLT_IL_MASK]);
    next_irq_low = !fault_pending;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state                 <= REG_OFF;
      tick_div              <= 16'h0000;
      ticks                 <= 7'h00;
      second_on             <= 1'b0;
      interrupt_request_low <= 1'b1;
      reg_rdata             <= 8'h00;
    end else begin
      state                 <= next_state;
      tick_div              <= next_tick_div;
      ticks                 <= next_ticks;
      second_on             <= next_on;
      interrupt_request_low <= next_irq_low;
      reg_rdata             <= next_rdata;
    end
  end

  assign discharge_current_select = delay_cfg[DLY_LOAD_HI:DLY_LOAD_LO];

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_hv_sticky: assert property (@(posedge clk) disable iff (!rstn)
    high_voltage_flag && !fault_read |=> high_voltage_flag)
    else $error("High-voltage flag dropped without a read.");
  chk_hv_sets: assert property (@(posedge clk) disable iff (!rstn)
    over_v |=> high_voltage_flag)
    else $error("High-voltage flag missed an event.");
  chk_il_clear: assert property (@(posedge clk) disable iff (!rstn)
    $fell(third_current_limit_flag) |-> $past(fault_read) && !$past(over_i))
    else $error("Current flag cleared without a read.");
  chk_on_cancel: assert property (@(posedge clk) disable iff (!rstn)
    state == REG_WAIT_ON && !enable_s |=> state == REG_OFF)
    else $error("Pending turn-on not cancelled.");
  chk_on_zero: assert property (@(posedge clk) disable iff (!rstn)
    state == REG_OFF && enable_s && delay_cfg[DLY_ON_HI:DLY_ON_LO] == 3'h0
    |=> ##1 second_on)
    else $error("Zero on-delay not honoured.");
  chk_on_wait: assert property (@(posedge clk) disable iff (!rstn)
    $rose(state == REG_WAIT_ON) && ticks != 7'h00 |-> !second_on [*8])
    else $error("Regulator turned on before its delay.");
  chk_off_zero: assert property (@(posedge clk) disable iff (!rstn)
    state == REG_ON && !enable_s && delay_cfg[DLY_OFF_HI:DLY_OFF_LO] == 3'h0
    |=> ##1 !second_on)
    else $error("Zero off-delay not honoured.");
  chk_irq_mask: assert property (@(posedge clk) disable iff (!rstn)
    (&masks) |=> interrupt_request_low)
    else $error("Masked faults reached the interrupt.");
  chk_irq_hv: assert property (@(posedge clk) disable iff (!rstn)
    high_voltage_flag && !masks[FLT_OV_MASK] |=> !interrupt_request_low)
    else $error("Unmasked high-voltage fault missed the interrupt.");
  chk_il_irq: assert property (@(posedge clk) disable iff (!rstn)
    third_current_limit_flag && !masks[FLT_IL_MASK] |=> !interrupt_request_low)
    else $error("Unmasked current fault missed the interrupt.");

  cov_turn_on:  cover property (@(posedge clk) disable iff (!rstn) $rose(second_on));
  cov_turn_off: cover property (@(posedge clk) disable iff (!rstn) $fell(second_on));
  cov_il_set:   cover property (@(posedge clk) disable iff (!rstn) $rose(third_current_limit_flag));
  cov_irq:      cover property (@(posedge clk) disable iff (!rstn) $fell(interrupt_request_low));

endmodule // regulator_delay_fault_regs

`default_nettype wire

/* verilog/regulator_pkg.sv */
package regulator_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_DELAY_CFG   = 8'h67;
  localparam logic [7:0] ADDR_FAULT_STAT  = 8'h80;
  localparam logic [7:0] RESET_DELAY_CFG  = 8'h08;
  localparam logic [3:0] RESET_MASKS      = 4'hF;

  // Delay register fields.
  localparam int DLY_LOAD_HI = 7;
  localparam int DLY_LOAD_LO = 6;
  localparam int DLY_ON_HI   = 5;
  localparam int DLY_ON_LO   = 3;
  localparam int DLY_OFF_HI  = 2;
  localparam int DLY_OFF_LO  = 0;

  // Fault register fields.
  localparam int FLT_GOOD    = 7;
  localparam int FLT_HIGH_V  = 6;
  localparam int FLT_CURRENT = 5;
  localparam int FLT_UV_MASK = 3;
  localparam int FLT_OV_MASK = 2;
  localparam int FLT_IL_MASK = 1;
  localparam int FLT_RSVD    = 0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ        = 50_000_000;
  localparam int TICK_US       = 500;
  localparam int TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
  localparam int CURRENT_COUNT = 16;

  // Delay in half-millisecond ticks per code; code 0 means no wait.
  function automatic logic [6:0] delay_ticks(input logic [2:0] code);
    delay_ticks = (code == 3'h0) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
  endfunction

  typedef struct packed {
    logic good;
    logic high_voltage;
    logic current_over;
    logic switch_cycle;
  } analog_status_t;

  typedef enum logic [1:0] {REG_OFF, REG_WAIT_ON, REG_ON, REG_WAIT_OFF} seq_state_t;

endpackage : regulator_pkg

/* test/analog_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_side_model
  import regulator_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           good,
  input  wire logic           high,
  input  wire logic           over,
  input  wire logic           fire,
  input  wire logic     [4:0] burst,
  output wire analog_status_t status
);
  logic sw = 1'b0;

  // Switching edges only come in counted bursts, so the bench knows the exact count.
  always @(posedge fire) begin
    repeat (burst) begin
      repeat (4) @(posedge clk);
      #1 sw = 1'b1;
      repeat (4) @(posedge clk);
      #1 sw = 1'b0;
    end
  end

  assign status = {good, high, over, sw};
endmodule // analog_side_model
`default_nettype wire

/* test/regulator_delay_fault_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module regulator_delay_fault_regs_test
  import regulator_pkg::*;
;
  logic           clk = 1'b0;
  logic           rstn = 1'b0;
  logic           reg_write = 1'b0;
  logic           reg_read = 1'b0;
  logic     [7:0] reg_addr = 8'h00;
  logic     [7:0] reg_wdata = 8'h00;
  logic     [7:0] reg_rdata;
  logic           en = 1'b0;
  logic           second_on;
  logic     [1:0] dsel;
  logic           irq_low;
  logic           good = 1'b0;
  logic           high = 1'b0;
  logic           over = 1'b0;
  logic           fire = 1'b0;
  logic     [4:0] burst = 5'h00;
  analog_status_t status;
  int             error_cnt = 0;
  int             cmp_count = 0;
  logic     [7:0] rd;

  always #10 clk = ~clk;

  analog_side_model model (.clk(clk), .good(good), .high(high), .over(over),
    .fire(fire), .burst(burst), .status(status));

  regulator_delay_fault_regs DUT (.clk(clk), .rstn(rstn), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .second_enable(en), .second_on(second_on),
    .discharge_current_select(dsel), .third_status(status),
    .interrupt_request_low(irq_low));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clk);
    #1 reg_write = 1'b0;
  endtask

  // The read strobe is what clears sticky flags, so every read is a real one.
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_read = 1'b1;
    @(posedge clk);
    #1 reg_read = 1'b0;
    d = reg_rdata;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Checks that second_on holds for most of one tick, then flips within a small margin.
  task automatic check_delay(input logic target);
    wait_cyc(TICK_CYCLES - 1000);
    chk({7'h00, second_on}, {7'h00, ~target});
    for (int i = 0; i < 1100 && second_on !== target; i++) wait_cyc(1);
    chk({7'h00, second_on}, {7'h00, target});
  endtask

  task automatic pulses(input logic [4:0] n);
    @(posedge clk);
    #1 burst = n;
    fire = 1'b1;
    wait_cyc(8 * n + 8);
    fire = 1'b0;
  endtask

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #1_900_000;
    error_cnt++;
    end_sim();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    rdr(ADDR_DELAY_CFG, rd);
    chk(rd, 8'h08);
    rdr(ADDR_FAULT_STAT, rd);
    chk(rd, 8'h0F);
    chk({7'h00, irq_low}, 8'h01);
    rdr(8'h55, rd);
    chk(rd, 8'h00);
    wr(ADDR_DELAY_CFG, 8'hC0);
    chk({6'h00, dsel}, 8'h03);
    en = 1'b1;
    wait_cyc(10);
    chk({7'h00, second_on}, 8'h01);
    wr(ADDR_DELAY_CFG, 8'h49);
    rdr(ADDR_DELAY_CFG, rd);
    chk(rd, 8'h49);
    chk({6'h00, dsel}, 8'h01);
    en = 1'b0;
    check_delay(1'b0);
    en = 1'b1;
    check_delay(1'b1);
    en = 1'b0;
    wait_cyc(1000);
    en = 1'b1;
    wait_cyc(TICK_CYCLES + 1000);
    chk({7'h00, second_on}, 8'h01);
    good = 1'b1;
    wait_cyc(5);
    wr(ADDR_FAULT_STAT, 8'h06);
    rdr(ADDR_FAULT_STAT, rd);
    chk(rd, 8'h87);
    chk({7'h00, irq_low}, 8'h01);
    good = 1'b0;
    wait_cyc(6);
    chk({7'h00, irq_low}, 8'h00);
    rdr(ADDR_FAULT_STAT, rd);
    chk(rd, 8'h07);
    wr(ADDR_FAULT_STAT, 8'h0E);
    wait_cyc(3);
    chk({7'h00, irq_low}, 8'h01);
    high = 1'b1;
    wait_cyc(6);
    chk({7'h00, irq_low}, 8'h01);
    high = 1'b0;
    wait_cyc(4);
    rdr(ADDR_FAULT_STAT, rd);
    chk(rd, 8'h4F);
    rdr(ADDR_FAULT_STAT, rd);
    chk(rd, 8'h0F);
    good = 1'b1;
    wr(ADDR_FAULT_STAT, 8'h00);
    high = 1'b1;
    wait_cyc(6);
    chk({7'h00, irq_low}, 8'h00);
    rdr(ADDR_FAULT_STAT, rd);
    chk(rd, 8'hC1);
    high = 1'b0;
    wait_cyc(4);
    rdr(ADDR_FAULT_STAT, rd);
    rdr(ADDR_FAULT_STAT, rd);
    chk(rd, 8'h81);
    wait_cyc(3);
    chk({7'h00, irq_low}, 8'h01);
    over = 1'b1;
    wait_cyc(4);
    pulses(5'h0F);
    rdr(ADDR_FAULT_STAT, rd);
    chk(rd, 8'h81);
    pulses(5'h01);
    rdr(ADDR_FAULT_STAT, rd);
    chk(rd, 8'hA1);
    chk({7'h00, irq_low}, 8'h00);
    wr(ADDR_FAULT_STAT, 8'h02);
    wait_cyc(3);
    chk({7'h00, irq_low}, 8'h01);
    over = 1'b0;
    wait_cyc(4);
    rdr(ADDR_FAULT_STAT, rd);
    chk(rd, 8'hA3);
    rdr(ADDR_FAULT_STAT, rd);
    chk(rd, 8'h83);
    end_sim();
  end
endmodule // regulator_delay_fault_regs_test
`default_nettype wire
